/* File: design/sch_defines.svh */
// Constants for the supervisory command handler: command codes,
// operands, reset values and timing figures.
// Assumes a 100 MHz system clock and a 12 MHz device oscillator reference.
`ifndef SCH_DEFINES_SVH
`define SCH_DEFINES_SVH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define SCH_CMD_RECAL       8'h62
`define SCH_CMD_LAST        8'h6C
`define SCH_CMD_RESET       8'h72
`define SCH_CMD_VERSION     8'h56
`define SCH_CMD_SIGNATURE   8'h57
`define SCH_CMD_SLEEP       8'h5A
`define SCH_CMD_RATE        8'h11
`define SCH_CMD_SCOPE_SYNC  8'h12
`define SCH_CMD_NOISE_SYNC  8'h17
`define SCH_CMD_DIR_GET     8'h67
`define SCH_CMD_DIR_PUT     8'h70

// ----------------------------------------------------------------
// Operands and reset values
// ----------------------------------------------------------------
`define SCH_OPERAND_NULL    8'h00
`define SCH_RATE_MAX        8'h04
`define SCH_FLAG_MAX        8'h01
`define SCH_RATE_RESET      3'h0
`define SCH_LAST_RESET      8'h00
// Version and signature bytes are arbitrary values of our own
`define SCH_VERSION_CODE    8'h21
`define SCH_SIGNATURE_CODE  8'hA5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCH_CLK_KHZ         100000
`define SCH_OSC_HZ          12000000
`define SCH_OPER_WAIT_MS    100
`define SCH_RESET_DELAY_MS  16
`define SCH_ECHO_WAIT_MS    2000
`define SCH_WAKE_LOW_US     10

// SPI master clock dividers and UART baud dividers from the oscillator
`define SCH_SPI_DIV0        (`SCH_OSC_HZ / 93750)
`define SCH_SPI_DIV1        (`SCH_OSC_HZ / 187500)
`define SCH_SPI_DIV2        (`SCH_OSC_HZ / 750000)
`define SCH_SPI_DIV3        (`SCH_OSC_HZ / 3000000)
`define SCH_BAUD_DIV0       (`SCH_OSC_HZ / 9600)
`define SCH_BAUD_DIV1       (`SCH_OSC_HZ / 14400)
`define SCH_BAUD_DIV2       (`SCH_OSC_HZ / 19200)
`define SCH_BAUD_DIV3       (`SCH_OSC_HZ / 38400)
`define SCH_BAUD_DIV4       (`SCH_OSC_HZ / 57600)

`endif

/* File: design/sch_pkg.sv */
// Types for the supervisory command handler.
// Constants live in sch_defines.svh.
package sch_pkg;

   // Gray codes along idle -> operand -> echo -> delay -> sleep
   typedef enum logic [2:0] {
      SCH_IDLE    = 3'h0,
      SCH_OPER    = 3'h1,
      SCH_ECHO    = 3'h3,
      SCH_RST_DLY = 3'h2,
      SCH_SLEEP   = 3'h6
   } sch_state_t;

   typedef enum logic [1:0] {
      SCH_ACT_NONE  = 2'h0,
      SCH_ACT_RESET = 2'h1,
      SCH_ACT_SLEEP = 2'h2
   } sch_act_t;

   typedef struct packed {
      logic [7:0]  spi_div;
      logic [10:0] baud_div;
   } sch_rate_t;

endpackage

/* File: design/sch_top.sv */
// Supervisory command interpreter of a touch-key sensor's host protocol.
// Assumes a byte link on its own clock (received bytes as strobes, echoes
// sent with valid/ready) and a sensing engine on CLK_IN.
`timescale 1ns/10ps
`include "sch_defines.svh"

module sch_top #(
   parameter logic [31:0] OPER_WAIT_CYC   = 32'(`SCH_OPER_WAIT_MS * `SCH_CLK_KHZ),
   parameter logic [31:0] RESET_DELAY_CYC = 32'(`SCH_RESET_DELAY_MS * `SCH_CLK_KHZ),
   parameter logic [31:0] ECHO_WAIT_CYC   = 32'(`SCH_ECHO_WAIT_MS * `SCH_CLK_KHZ)
) (
   input  wire logic        CLK_IN,
   input  wire logic        RST_IN,
   input  wire logic        LINK_CLK_IN,
   input  wire logic [7:0]  RX_DATA_IN,
   input  wire logic        RX_VALID_IN,
   output logic      [7:0]  TX_DATA_OUT,
   output logic             TX_VALID_OUT,
   input  wire logic        TX_READY_IN,
   input  wire logic        WAKE_N_IN,
   input  wire logic        BURST_ACTIVE_IN,
   output logic             RECAL_START_OUT,
   output logic             SOFT_RESET_OUT,
   output logic             SLEEP_OUT,
   output logic             PUT_MODE_OUT,
   output logic             SYNC_OUT,
   output logic             NOISE_SYNC_OUT,
   output logic      [2:0]  RATE_SEL_OUT,
   output logic      [7:0]  SPI_DIV_OUT,
   output logic      [10:0] BAUD_DIV_OUT
);

   localparam logic [31:0] WAKE_LOW_CYC =
      32'((`SCH_WAKE_LOW_US * `SCH_CLK_KHZ + 999) / 1000);

   // ----------------------------------------------------------------
   // Link domain: receive capture and echo transmit
   // ----------------------------------------------------------------
   logic [7:0] rx_hold_reg;
   logic       rx_tgl_reg;
   logic       txq_s1_reg;
   logic       txq_s2_reg;
   logic       txq_seen_reg;
   logic       tx_ack_tgl_reg;
   logic [7:0] tx_data_reg;
   logic       tx_tgl_reg;

   wire tx_load = (txq_s2_reg != txq_seen_reg) && !TX_VALID_OUT;
   wire tx_take = TX_VALID_OUT && TX_READY_IN;

   // Reception never depends on the selected rate: bytes are taken as
   // fast as the link clock delivers them.
   always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         rx_hold_reg <= 8'h00;
         rx_tgl_reg  <= 1'b0;
      end else if (RX_VALID_IN) begin
         rx_hold_reg <= RX_DATA_IN;
         rx_tgl_reg  <= ~rx_tgl_reg;
      end
   end

   always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         txq_s1_reg     <= 1'b0;
         txq_s2_reg     <= 1'b0;
         txq_seen_reg   <= 1'b0;
         tx_ack_tgl_reg <= 1'b0;
         TX_DATA_OUT    <= 8'h00;
         TX_VALID_OUT   <= 1'b0;
      end else begin
         txq_s1_reg <= tx_tgl_reg;
         txq_s2_reg <= txq_s1_reg;
         if (tx_load) begin
            TX_DATA_OUT  <= tx_data_reg;
            TX_VALID_OUT <= 1'b1;
            txq_seen_reg <= txq_s2_reg;
         end else if (tx_take) begin
            TX_VALID_OUT   <= 1'b0;
            tx_ack_tgl_reg <= ~tx_ack_tgl_reg;
         end
      end
   end

   // ----------------------------------------------------------------
   // System domain synchronisers
   // ----------------------------------------------------------------
   logic rx_s1_reg;
   logic rx_s2_reg;
   logic rx_s3_reg;
   logic ack_s1_reg;
   logic ack_s2_reg;
   logic ack_s3_reg;
   logic wake_s1_reg;
   logic wake_s2_reg;

   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         rx_s1_reg   <= 1'b0;
         rx_s2_reg   <= 1'b0;
         rx_s3_reg   <= 1'b0;
         ack_s1_reg  <= 1'b0;
         ack_s2_reg  <= 1'b0;
         ack_s3_reg  <= 1'b0;
         wake_s1_reg <= 1'b1;
         wake_s2_reg <= 1'b1;
      end else begin
         rx_s1_reg   <= rx_tgl_reg;
         rx_s2_reg   <= rx_s1_reg;
         rx_s3_reg   <= rx_s2_reg;
         ack_s1_reg  <= tx_ack_tgl_reg;
         ack_s2_reg  <= ack_s1_reg;
         ack_s3_reg  <= ack_s2_reg;
         wake_s1_reg <= WAKE_N_IN;
         wake_s2_reg <= wake_s1_reg;
      end
   end

   // Held byte is stable long before the toggle arrives through two stages
   wire       rx_evt  = rx_s2_reg ^ rx_s3_reg;
   wire       tx_done = ack_s2_reg ^ ack_s3_reg;
   wire [7:0] rx_byte = rx_hold_reg;

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   sch_pkg::sch_state_t state_reg;
   sch_pkg::sch_state_t state_next;
   sch_pkg::sch_act_t   act_reg;
   sch_pkg::sch_act_t   act_next;
   logic [31:0] timer_reg;
   logic [31:0] timer_next;
   logic [7:0]  cmd_reg;
   logic [7:0]  cmd_next;
   logic [7:0]  last_cmd_reg;
   logic [7:0]  last_cmd_next;
   logic        put_mode_reg;
   logic        put_mode_next;
   logic        scope_sync_reg;
   logic        scope_sync_next;
   logic [2:0]  rate_pend_reg;
   logic [2:0]  rate_pend_next;
   logic [2:0]  rate_act_reg;
   logic        noise_pend_reg;
   logic        noise_pend_next;
   logic        noise_act_reg;
   logic        sleep_reg;
   logic        sleep_next;
   logic        recal_next;
   logic        fire_reset;
   logic        tx_go;
   logic [7:0]  tx_byte;

   wire needs_operand = (rx_byte == `SCH_CMD_RESET) || (rx_byte == `SCH_CMD_SLEEP) ||
                        (rx_byte == `SCH_CMD_RATE) || (rx_byte == `SCH_CMD_SCOPE_SYNC) ||
                        (rx_byte == `SCH_CMD_NOISE_SYNC);
   wire get_readable  = (rx_byte == `SCH_CMD_SCOPE_SYNC) ||
                        (rx_byte == `SCH_CMD_NOISE_SYNC);
   wire op_null       = rx_byte == `SCH_OPERAND_NULL;
   wire op_flag_ok    = rx_byte <= `SCH_FLAG_MAX;
   wire op_rate_ok    = rx_byte <= `SCH_RATE_MAX;
   wire oper_expired  = timer_reg >= OPER_WAIT_CYC - 32'h1;
   wire echo_expired  = timer_reg >= ECHO_WAIT_CYC - 32'h1;
   wire delay_done    = timer_reg >= RESET_DELAY_CYC - 32'h1;
   wire wake_done     = !wake_s2_reg && (timer_reg >= WAKE_LOW_CYC - 32'h1);

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_next      = state_reg;
      act_next        = act_reg;
      cmd_next        = cmd_reg;
      last_cmd_next   = last_cmd_reg;
      put_mode_next   = put_mode_reg;
      scope_sync_next = scope_sync_reg;
      rate_pend_next  = rate_pend_reg;
      noise_pend_next = noise_pend_reg;
      sleep_next      = sleep_reg;
      recal_next      = 1'b0;
      fire_reset      = 1'b0;
      tx_go           = 1'b0;
      tx_byte         = rx_byte;
      timer_next      = timer_reg + 32'h1;
      case (state_reg)
         sch_pkg::SCH_IDLE: begin
            if (rx_evt) begin
               last_cmd_next = rx_byte;
               case (rx_byte)
                  `SCH_CMD_DIR_GET: begin
                     put_mode_next = 1'b0;
                     tx_go         = 1'b1;
                  end
                  `SCH_CMD_DIR_PUT: begin
                     put_mode_next = 1'b1;
                     tx_go         = 1'b1;
                  end
                  `SCH_CMD_RECAL: begin
                     recal_next = put_mode_reg;
                     tx_go      = put_mode_reg;
                  end
                  `SCH_CMD_LAST: begin
                     tx_go   = !put_mode_reg;
                     tx_byte = last_cmd_reg;
                  end
                  `SCH_CMD_VERSION: begin
                     tx_go   = !put_mode_reg;
                     tx_byte = `SCH_VERSION_CODE;
                  end
                  `SCH_CMD_SIGNATURE: begin
                     tx_go   = !put_mode_reg;
                     tx_byte = `SCH_SIGNATURE_CODE;
                  end
                  default: begin
                     if (needs_operand && put_mode_reg) begin
                        cmd_next   = rx_byte;
                        state_next = sch_pkg::SCH_OPER;
                     end else if (get_readable && !put_mode_reg) begin
                        tx_go   = 1'b1;
                        tx_byte = (rx_byte == `SCH_CMD_SCOPE_SYNC) ?
                                  {7'h00, scope_sync_reg} : {7'h00, noise_pend_reg};
                     end
                  end
               endcase
               if (tx_go) begin
                  act_next   = sch_pkg::SCH_ACT_NONE;
                  state_next = sch_pkg::SCH_ECHO;
               end
            end
         end
         sch_pkg::SCH_OPER: begin
            if (rx_evt) begin
               state_next = sch_pkg::SCH_IDLE;
               tx_byte    = cmd_reg;
               act_next   = sch_pkg::SCH_ACT_NONE;
               case (cmd_reg)
                  `SCH_CMD_RESET: begin
                     tx_go    = op_null;
                     act_next = sch_pkg::SCH_ACT_RESET;
                  end
                  `SCH_CMD_SLEEP: begin
                     tx_go    = op_null;
                     act_next = sch_pkg::SCH_ACT_SLEEP;
                  end
                  `SCH_CMD_RATE: begin
                     tx_go = op_rate_ok;
                     if (op_rate_ok) begin
                        rate_pend_next = rx_byte[2:0];
                     end
                  end
                  `SCH_CMD_SCOPE_SYNC: begin
                     tx_go = op_flag_ok;
                     if (op_flag_ok) begin
                        scope_sync_next = rx_byte[0];
                     end
                  end
                  `SCH_CMD_NOISE_SYNC: begin
                     tx_go = op_flag_ok;
                     if (op_flag_ok) begin
                        noise_pend_next = rx_byte[0];
                     end
                  end
                  default: begin
                     tx_go = 1'b0;
                  end
               endcase
               if (tx_go) begin
                  state_next = sch_pkg::SCH_ECHO;
               end
            end else if (oper_expired) begin
               state_next = sch_pkg::SCH_IDLE;
            end
         end
         sch_pkg::SCH_ECHO: begin
            if (tx_done) begin
               case (act_reg)
                  sch_pkg::SCH_ACT_RESET: state_next = sch_pkg::SCH_RST_DLY;
                  sch_pkg::SCH_ACT_SLEEP: begin
                     sleep_next = 1'b1;
                     state_next = sch_pkg::SCH_SLEEP;
                  end
                  default: state_next = sch_pkg::SCH_IDLE;
               endcase
            end else if (echo_expired) begin
               // Echo stuck: a held-off sleep echo ends in a full reset,
               // a held-off reset echo just drops the command
               fire_reset = act_reg == sch_pkg::SCH_ACT_SLEEP;
               state_next = sch_pkg::SCH_IDLE;
            end
         end
         sch_pkg::SCH_RST_DLY: begin
            if (delay_done) begin
               fire_reset = 1'b1;
               state_next = sch_pkg::SCH_IDLE;
            end
         end
         sch_pkg::SCH_SLEEP: begin
            timer_next = wake_s2_reg ? 32'h0 : timer_reg + 32'h1;
            if (wake_done) begin
               // Put mode drops back to Get; other settings and calibration stay as they were before sleep
               sleep_next    = 1'b0;
               put_mode_next = 1'b0;
               tx_go         = 1'b1;
               tx_byte       = `SCH_CMD_SLEEP;
               act_next      = sch_pkg::SCH_ACT_NONE;
               state_next    = sch_pkg::SCH_ECHO;
            end
         end
         default: state_next = sch_pkg::SCH_IDLE;
      endcase
      if (state_next != state_reg) begin
         timer_next = 32'h0;
      end
      if (fire_reset) begin
         put_mode_next   = 1'b0;
         scope_sync_next = 1'b0;
         last_cmd_next   = `SCH_LAST_RESET;
         sleep_next      = 1'b0;
      end
   end

   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         state_reg      <= sch_pkg::SCH_IDLE;
         act_reg        <= sch_pkg::SCH_ACT_NONE;
         timer_reg      <= 32'h0;
         cmd_reg        <= 8'h00;
         last_cmd_reg   <= `SCH_LAST_RESET;
         put_mode_reg   <= 1'b0;
         scope_sync_reg <= 1'b0;
         rate_pend_reg  <= `SCH_RATE_RESET;
         noise_pend_reg <= 1'b0;
         sleep_reg      <= 1'b0;
      end else begin
         state_reg      <= state_next;
         act_reg        <= act_next;
         timer_reg      <= timer_next;
         cmd_reg        <= cmd_next;
         last_cmd_reg   <= last_cmd_next;
         put_mode_reg   <= put_mode_next;
         scope_sync_reg <= scope_sync_next;
         rate_pend_reg  <= rate_pend_next;
         noise_pend_reg <= noise_pend_next;
         sleep_reg      <= sleep_next;
      end
   end

   // ----------------------------------------------------------------
   // Echo launch and settings that wait for a reset
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         tx_data_reg <= 8'h00;
         tx_tgl_reg  <= 1'b0;
      end else if (tx_go) begin
         tx_data_reg <= tx_byte;
         tx_tgl_reg  <= ~tx_tgl_reg;
      end
   end

   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         rate_act_reg  <= `SCH_RATE_RESET;
         noise_act_reg <= 1'b0;
      end else if (fire_reset) begin
         rate_act_reg  <= rate_pend_reg;
         noise_act_reg <= noise_pend_reg;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   sch_pkg::sch_rate_t rate_lut;

   // SPI has four codes; code 4 is a UART-only rate and keeps the fastest SPI clock
   always_comb begin
      case (rate_act_reg)
         3'h0:    rate_lut = '{8'(`SCH_SPI_DIV0), 11'(`SCH_BAUD_DIV0)};
         3'h1:    rate_lut = '{8'(`SCH_SPI_DIV1), 11'(`SCH_BAUD_DIV1)};
         3'h2:    rate_lut = '{8'(`SCH_SPI_DIV2), 11'(`SCH_BAUD_DIV2)};
         3'h3:    rate_lut = '{8'(`SCH_SPI_DIV3), 11'(`SCH_BAUD_DIV3)};
         default: rate_lut = '{8'(`SCH_SPI_DIV3), 11'(`SCH_BAUD_DIV4)};
      endcase
   end

   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         RECAL_START_OUT <= 1'b0;
         SOFT_RESET_OUT  <= 1'b0;
         SYNC_OUT        <= 1'b0;
         SPI_DIV_OUT     <= 8'h00;
         BAUD_DIV_OUT    <= 11'h000;
      end else begin
         RECAL_START_OUT <= recal_next;
         SOFT_RESET_OUT  <= fire_reset;
         SYNC_OUT        <= scope_sync_reg && BURST_ACTIVE_IN;
         SPI_DIV_OUT     <= rate_lut.spi_div;
         BAUD_DIV_OUT    <= rate_lut.baud_div;
      end
   end

   assign SLEEP_OUT      = sleep_reg;
   assign PUT_MODE_OUT   = put_mode_reg;
   assign NOISE_SYNC_OUT = noise_act_reg;
   assign RATE_SEL_OUT   = rate_act_reg;

endmodule

/* File: testbench/sch_host_model.sv */
// Host on the far side of the byte link.
// Bench calls send() and sets stall or slow; echoes land in got.
`timescale 1ns/10ps
module sch_host_model (
   input  wire logic       lclk_in,
   input  wire logic [7:0] tx_data_in,
   input  wire logic       tx_valid_in,
   output logic      [7:0] rx_data_out,
   output logic            rx_valid_out,
   output logic            tx_ready_out
);
   logic [7:0] got [$];
   logic       stall = 1'b0;
   logic       slow  = 1'b0;
   initial rx_valid_out = 1'b0;
   initial rx_data_out = 8'h00;
   initial tx_ready_out = 1'b0;
   // Operand follows promptly; released data inverted, never left stale
   task automatic send(input logic [7:0] b);
      @(negedge lclk_in);
      rx_data_out = b;
      rx_valid_out = 1'b1;
      @(negedge lclk_in);
      rx_valid_out = 1'b0;
      rx_data_out = ~b;
   endtask
   always @(negedge lclk_in) tx_ready_out <= !stall && !(slow && tx_ready_out);
   always @(posedge lclk_in) if (tx_valid_in && tx_ready_out) got.push_back(tx_data_in);
endmodule

/* File: testbench/sch_top_bench.sv */
// Self-checking bench for the supervisory command handler.
// Assumes short timing parameters and the host model on the link.
`timescale 1ns/10ps
`include "sch_defines.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
   $display("unexpected at %0t: got %0h want %0h", $time, a, e); end end
module sch_top_bench;
   logic        clk = 1'b0;
   logic        lclk = 1'b0;
   logic        rst = 1'b1;
   logic        wake_n = 1'b1;
   logic        burst = 1'b0;
   logic [7:0]  tx_data, rx_data, spi;
   logic        tx_valid, rx_valid, tx_ready, recal, sres, sleep, put, sync, noise;
   logic [2:0]  rate;
   logic [10:0] baud;
   logic [31:0] seed = 32'h52EB;
   int          n_mismatch = 0, check_count = 0, cyc = 0, n_recal = 0, n_sres = 0, n_sync = 0;
   int          put_m = 0, last_c = 0, rate_p = 0, rate_e = 0, scope = 0, nz_p = 0, nz_e = 0;
   int          k;
   int          spi_t [5] = '{128, 64, 16, 4, 4};
   int          baud_t [5] = '{1250, 833, 625, 312, 208};
   sch_top #(.OPER_WAIT_CYC(32'h0C8), .RESET_DELAY_CYC(32'h032), .ECHO_WAIT_CYC(32'h190)) DUT (
      .CLK_IN(clk), .RST_IN(rst), .LINK_CLK_IN(lclk), .RX_DATA_IN(rx_data),
      .RX_VALID_IN(rx_valid), .TX_DATA_OUT(tx_data), .TX_VALID_OUT(tx_valid),
      .TX_READY_IN(tx_ready), .WAKE_N_IN(wake_n), .BURST_ACTIVE_IN(burst),
      .RECAL_START_OUT(recal), .SOFT_RESET_OUT(sres), .SLEEP_OUT(sleep), .PUT_MODE_OUT(put),
      .SYNC_OUT(sync), .NOISE_SYNC_OUT(noise), .RATE_SEL_OUT(rate), .SPI_DIV_OUT(spi),
      .BAUD_DIV_OUT(baud));
   sch_host_model H (.lclk_in(lclk), .tx_data_in(tx_data), .tx_valid_in(tx_valid),
      .rx_data_out(rx_data), .rx_valid_out(rx_valid), .tx_ready_out(tx_ready));
   initial forever #5 clk = ~clk;
   initial begin
      #37;
      forever #62.5 lclk = ~lclk;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   always @(negedge clk) burst <= xs() > 32'h8000_0000;
   always @(posedge clk) begin
      cyc++;
      n_recal += recal;
      n_sres += sres;
      n_sync += sync;
      if (cyc == 60000) begin
         n_mismatch++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ----
   // Reference model: expected answer, -1 none, -2 any
   // ----
   task automatic echo(input int e);
      int n;
      n = 0;
      if (H.stall) e = -2;
      while (H.got.size() == 0 && n < 24) begin
         @(posedge lclk);
         n++;
      end
      if (e == -1)
         `CHK(H.got.size(), 0)
      else if (e >= 0)
         `CHK(H.got[0], e)
      H.got.delete();
   endtask
   task automatic cmd(input int op, input int arg = -1);
      int e;
      case (op)
         8'h6C: e = put_m ? -1 : last_c;
         8'h56: e = put_m ? -1 : `SCH_VERSION_CODE;
         8'h57: e = put_m ? -1 : `SCH_SIGNATURE_CODE;
         8'h62: e = put_m ? op : -1;
         8'h72, 8'h5A: e = put_m && arg == 0 ? op : -1;
         8'h11: e = put_m && arg <= 4 ? op : -1;
         8'h12: e = put_m ? op : scope;
         8'h17: e = put_m ? op : nz_p;
         8'h67, 8'h70: e = op;
         default: e = -2;
      endcase
      if (op == 8'h11 && e > 0) rate_p = arg;
      if (op == 8'h12 && put_m) scope = arg;
      if (op == 8'h17 && put_m) nz_p = arg;
      if (op == 8'h67 || op == 8'h70) put_m = op[4];
      last_c = op;
      H.got.delete();
      H.send(8'(op));
      if (arg >= 0) H.send(8'(arg));
      echo(e);
   endtask
   task automatic settle();
      repeat (120) @(posedge clk);
      put_m = 0;
      last_c = 0;
      scope = 0;
      rate_e = rate_p;
      nz_e = nz_p;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      repeat (2) @(posedge lclk);
      `CHK(put, 1'b0)
      cmd(8'h56);
      cmd(8'h57);
      cmd(8'h62);
      cmd(8'h6C);
      cmd(8'h6C);
      cmd(int'(xs() % 32'h80) + 32'h80);
      cmd(8'h6C);
      cmd(8'h70);
      cmd(8'h56);
      cmd(8'h62);
      cmd(8'h62);
      `CHK(n_recal, 2)
      cmd(8'h12, 1);
      repeat (100) @(posedge clk);
      `CHK(n_sync > 0, 1'b1)
      cmd(8'h5A, 1);
      cmd(8'h72);
      `CHK(n_sres, 0)
      for (k = 0; k < 5; k++) begin
         cmd(8'h70);
         cmd(8'h11, k);
         cmd(8'h17, k % 2);
         `CHK(rate, 3'(rate_e))
         `CHK(noise, 1'(nz_e))
         cmd(8'h72, 0);
         settle();
         `CHK(rate, 3'(rate_e))
         `CHK(spi, 8'(spi_t[k]))
         `CHK(baud, 11'(baud_t[k]))
         `CHK(noise, 1'(nz_e))
         `CHK(put, 1'b0)
         cmd(8'h12);
         cmd(8'h17);
      end
      `CHK(n_sres, 5)
      k = n_sync;
      repeat (100) @(posedge clk);
      `CHK(n_sync, k)
      cmd(8'h70);
      H.stall = 1'b1;
      cmd(8'h72, 0);
      repeat (600) @(posedge clk);
      H.stall = 1'b0;
      echo(-2);
      `CHK(n_sres, 5)
      `CHK(put, 1'b1)
      cmd(8'h5A, 0);
      repeat (10) @(posedge clk);
      `CHK(sleep, 1'b1)
      @(negedge clk) wake_n = 1'b0;
      repeat (500) @(negedge clk);
      wake_n = 1'b1;
      repeat (10) @(negedge clk);
      `CHK(sleep, 1'b1)
      wake_n = 1'b0;
      repeat (1100) @(negedge clk);
      wake_n = 1'b1;
      put_m = 0;
      echo(8'h5A);
      `CHK(sleep, 1'b0)
      `CHK(put, 1'b0)
      `CHK(n_recal, 2)
      cmd(8'h70);
      H.stall = 1'b1;
      cmd(8'h5A, 0);
      repeat (600) @(posedge clk);
      H.stall = 1'b0;
      echo(-2);
      `CHK(n_sres, 6)
      settle();
      H.slow = 1'b1;
      cmd(8'h70);
      cmd(8'h67);
      cmd(8'h56);
      stop_test();
   end
endmodule

/* File: testbench/sch_top_props.sv */
// Port checks for the supervisory command handler.
// Bound into sch_top; watches only CLK_IN-domain ports.
`timescale 1ns/10ps
module sch_top_props (
   input wire logic        CLK_IN,
   input wire logic        RST_IN,
   input wire logic        WAKE_N_IN,
   input wire logic        BURST_ACTIVE_IN,
   input wire logic        RECAL_START_OUT,
   input wire logic        SOFT_RESET_OUT,
   input wire logic        SLEEP_OUT,
   input wire logic        PUT_MODE_OUT,
   input wire logic        SYNC_OUT,
   input wire logic [2:0]  RATE_SEL_OUT,
   input wire logic [7:0]  SPI_DIV_OUT,
   input wire logic [10:0] BAUD_DIV_OUT
);
   // ----
   // Divider tables, codes 0..4
   // ----
   localparam logic [7:0]  SPI_TAB [5]  = '{8'h80, 8'h40, 8'h10, 8'h04, 8'h04};
   localparam logic [10:0] BAUD_TAB [5] = '{11'h4E2, 11'h341, 11'h271, 11'h138, 11'h0D0};
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);
   // Two quiet cycles, so a divider lagging one cycle is tolerated
   sequence rate_settled;
      $stable(RATE_SEL_OUT) ##1 $stable(RATE_SEL_OUT);
   endsequence
   sequence get_soon;
      ##[0:2] !PUT_MODE_OUT;
   endsequence
   chk_sync_burst: assert property (
      SYNC_OUT |-> $past(BURST_ACTIVE_IN)) else $error("sync outside a burst");
   chk_recal_put: assert property (
      RECAL_START_OUT |-> PUT_MODE_OUT) else $error("recalibration in Get mode");
   chk_reset_get: assert property (
      SOFT_RESET_OUT |-> get_soon) else $error("Put mode kept over soft reset");
   // Effective rate and reset pulse leave flip-flops on the same edge
   chk_rate_hold: assert property (
      $changed(RATE_SEL_OUT) |-> SOFT_RESET_OUT)
      else $error("rate changed without reset");
   chk_div_table: assert property (
      rate_settled |-> SPI_DIV_OUT == SPI_TAB[RATE_SEL_OUT]
      && BAUD_DIV_OUT == BAUD_TAB[RATE_SEL_OUT]) else $error("divider off its table");
   chk_sleep_get: assert property (
      $fell(SLEEP_OUT) |-> get_soon) else $error("woke in Put mode");
   chk_wake_pin: assert property (
      $fell(SLEEP_OUT) |-> !$past(WAKE_N_IN, 4) && !$past(WAKE_N_IN, 8))
      else $error("woke without wake pin low");
   chk_sleep_quiet: assert property (
      SLEEP_OUT |-> !RECAL_START_OUT) else $error("recalibration while asleep");
endmodule
bind sch_top sch_top_props u_props (
   .CLK_IN(CLK_IN), .RST_IN(RST_IN), .WAKE_N_IN(WAKE_N_IN),
   .BURST_ACTIVE_IN(BURST_ACTIVE_IN), .RECAL_START_OUT(RECAL_START_OUT),
   .SOFT_RESET_OUT(SOFT_RESET_OUT), .SLEEP_OUT(SLEEP_OUT), .PUT_MODE_OUT(PUT_MODE_OUT),
   .SYNC_OUT(SYNC_OUT), .RATE_SEL_OUT(RATE_SEL_OUT), .SPI_DIV_OUT(SPI_DIV_OUT),
   .BAUD_DIV_OUT(BAUD_DIV_OUT));
